/* File: rtl/see_top.sv */
// Two-wire serial EEPROM slave: bit engine, page latch, timed programming, storage array.
`include "see_defines.svh"

module see_top
    import see_pkg::*;
#(
    parameter int PROG_CYCLES = `SEE_PROG_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic power_good,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    input  wire logic select_pin_0,
    input  wire logic select_pin_1,
    input  wire logic select_pin_2,
    input  wire logic write_protect,
    output logic      standby,
    output logic      prog_active
);
    // Storage array and page latch.
    logic [`SEE_BYTE_W-1:0]     mem       [`SEE_MEM_BYTES];
    logic [`SEE_BYTE_W-1:0]     page_data [`SEE_PAGE_BYTES];
    logic [`SEE_PAGE_BYTES-1:0] page_mask;
    logic [`SEE_LOC_W-`SEE_PAGE_W-1:0] page_base;

    // Synchronisers.
    logic [`SEE_SYNC_W-1:0] sync1;
    logic [`SEE_SYNC_W-1:0] sync2;
    logic                   scl_d;
    logic                   sda_d;
    logic                   pg_s;
    logic                   scl_s;
    logic                   sda_s;
    logic                   wp_s;
    logic [2:0]             sel_s;

    // Bit engine.
    see_state_t             state;
    logic [3:0]             bit_cnt;
    logic                   in_ack;
    logic [`SEE_BYTE_W-1:0] shift;
    logic [`SEE_BYTE_W-1:0] tx;
    logic [`SEE_LOC_W-1:0]  ptr;
    logic                   wr_pend;
    logic                   prog_req;
    logic                   page_clr;
    logic                   push;
    see_wr_t                push_data;

    // Programming.
    logic                      prog_want;
    logic                      prog_busy;
    logic [`SEE_PROG_CNT_W-1:0] prog_cnt;
    logic                      busy;
    logic [`SEE_PAGE_W-1:0]    cp_idx;

    // FIFO fill ready and drain side.
    logic    fifo_in_ready;
    logic    fifo_out_valid;
    logic    fifo_out_ready;
    see_wr_t fifo_out;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic dev_match;

    function automatic logic [`SEE_PAGE_W-1:0] page_next(input logic [`SEE_PAGE_W-1:0] idx);
        page_next = idx + 1'b1;
    endfunction

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            // Clock and data reset to their released level so no false edge follows reset.
            sync1 <= `SEE_SYNC_IDLE;
            sync2 <= `SEE_SYNC_IDLE;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {power_good, scl_in, sda_in, write_protect,
                      select_pin_2, select_pin_1, select_pin_0};
            sync2 <= sync1;
            scl_d <= sync2[5];
            sda_d <= sync2[4];
        end
    end

    assign pg_s  = sync2[6];
    assign scl_s = sync2[5];
    assign sda_s = sync2[4];
    assign wp_s  = sync2[3];
    assign sel_s = sync2[2:0];

    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
    // Floating select pins read low through the board pull-downs.
    assign dev_match = (shift[7:1] == {`SEE_DEV_ID, sel_s});
    assign busy      = prog_want || prog_busy;
    assign sda_out   = 1'b0;
    assign prog_active = busy;
    assign cp_idx    = prog_cnt[`SEE_PAGE_W-1:0];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state     <= SEE_ST_IDLE;
            bit_cnt   <= '0;
            in_ack    <= 1'b0;
            shift     <= '0;
            tx        <= '0;
            ptr       <= '0;
            wr_pend   <= 1'b0;
            prog_req  <= 1'b0;
            page_clr  <= 1'b0;
            push      <= 1'b0;
            push_data <= '0;
            sda_oe_n  <= 1'b1;
        end else begin
            prog_req <= 1'b0;
            page_clr <= 1'b0;
            push     <= 1'b0;
            if (!pg_s || start_det || stop_det) begin
                bit_cnt  <= '0;
                in_ack   <= 1'b0;
                sda_oe_n <= 1'b1;
                wr_pend  <= 1'b0;
                state    <= (pg_s && start_det) ? SEE_ST_DEVADDR : SEE_ST_IDLE;
                prog_req <= pg_s && stop_det && wr_pend;
            end else if (scl_rise) begin
                if (in_ack) begin
                    if (state == SEE_ST_RDATA && sda_s) begin
                        state <= SEE_ST_IGNORE;
                    end
                end else if (bit_cnt != `SEE_BITS_PER_BYTE) begin
                    shift   <= {shift[6:0], sda_s};
                    bit_cnt <= bit_cnt + 1'b1;
                end
            end else if (scl_fall && state != SEE_ST_IDLE && state != SEE_ST_IGNORE) begin
                if (in_ack) begin
                    in_ack   <= 1'b0;
                    bit_cnt  <= '0;
                    sda_oe_n <= 1'b1;
                    if (state == SEE_ST_RDATA) begin
                        tx       <= {mem[ptr][6:0], 1'b0};
                        sda_oe_n <= mem[ptr][7];
                    end
                end else if (bit_cnt == `SEE_BITS_PER_BYTE) begin
                    in_ack <= 1'b1;
                    unique case (state)
                        SEE_ST_DEVADDR: begin
                            if (dev_match && !busy) begin
                                sda_oe_n <= 1'b0;
                                state    <= shift[0] ? SEE_ST_RDATA : SEE_ST_LOC_HI;
                                page_clr <= !shift[0];
                            end else begin
                                state <= SEE_ST_IGNORE;
                            end
                        end
                        SEE_ST_LOC_HI: begin
                            ptr[`SEE_LOC_W-1:`SEE_BYTE_W] <= shift[`SEE_LOC_HI_W-1:0];
                            sda_oe_n <= 1'b0;
                            state    <= SEE_ST_LOC_LO;
                        end
                        SEE_ST_LOC_LO: begin
                            ptr[`SEE_BYTE_W-1:0] <= shift;
                            sda_oe_n <= 1'b0;
                            state    <= SEE_ST_WDATA;
                        end
                        SEE_ST_WDATA: begin
                            if (!wp_s && fifo_in_ready) begin
                                push           <= 1'b1;
                                push_data.loc  <= ptr;
                                push_data.data <= shift;
                                wr_pend        <= 1'b1;
                                sda_oe_n       <= 1'b0;
                                ptr[`SEE_PAGE_W-1:0] <= page_next(ptr[`SEE_PAGE_W-1:0]);
                            end else begin
                                state <= SEE_ST_IGNORE;
                            end
                        end
                        SEE_ST_RDATA: begin
                            sda_oe_n <= 1'b1;
                            ptr      <= ptr + 1'b1;
                        end
                        default: begin
                            state <= SEE_ST_IGNORE;
                        end
                    endcase
                end else if (state == SEE_ST_RDATA) begin
                    sda_oe_n <= tx[7];
                    tx       <= {tx[6:0], 1'b0};
                end
            end
        end
    end

    // Received bytes pass through the FIFO into the page latch.
    see_fifo #(
        .WIDTH($bits(see_wr_t)),
        .DEPTH(`SEE_FIFO_DEPTH)
    ) i_see_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    assign fifo_out_ready = !prog_busy;

    always_ff @(posedge clk_sys) begin
        if (fifo_out_valid && fifo_out_ready) begin
            page_data[fifo_out.loc[`SEE_PAGE_W-1:0]] <= fifo_out.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            page_mask <= '0;
            page_base <= '0;
        end else if (!pg_s || page_clr ||
                     (prog_busy && prog_cnt == `SEE_PROG_CNT_W'(PROG_CYCLES - 1))) begin
            page_mask <= '0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            page_mask[fifo_out.loc[`SEE_PAGE_W-1:0]] <= 1'b1;
            page_base <= fifo_out.loc[`SEE_LOC_W-1:`SEE_PAGE_W];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prog_want <= 1'b0;
            prog_busy <= 1'b0;
            prog_cnt  <= '0;
        end else if (!pg_s) begin
            prog_want <= 1'b0;
            prog_busy <= 1'b0;
            prog_cnt  <= '0;
        end else if (prog_req) begin
            prog_want <= 1'b1;
        end else if (prog_want && !fifo_out_valid) begin
            prog_want <= 1'b0;
            prog_busy <= 1'b1;
            prog_cnt  <= '0;
        end else if (prog_busy) begin
            prog_cnt <= prog_cnt + 1'b1;
            if (prog_cnt == `SEE_PROG_CNT_W'(PROG_CYCLES - 1)) begin
                prog_busy <= 1'b0;
            end
        end
    end

    // The page latch is copied into the array early in the programming time.
    always_ff @(posedge clk_sys) begin
        if (prog_busy && prog_cnt < `SEE_PROG_CNT_W'(`SEE_PAGE_BYTES) && page_mask[cp_idx]) begin
            mem[{page_base, cp_idx}] <= page_data[cp_idx];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            standby <= 1'b1;
        end else begin
            standby <= (state == SEE_ST_IDLE) && !busy;
        end
    end
endmodule

/* File: pkg/see_defines.svh */
// Constants for the two-wire serial EEPROM slave.
`ifndef SEE_DEFINES_SVH
`define SEE_DEFINES_SVH

`define SEE_MEM_BYTES      16384
`define SEE_LOC_W          14
`define SEE_PAGE_BYTES     64
`define SEE_PAGE_W         6
`define SEE_BYTE_W         8
`define SEE_BITS_PER_BYTE  4'h8
`define SEE_DEV_ID         4'ha
`define SEE_LOC_HI_W       6
`define SEE_FIFO_DEPTH     32
`define SEE_CLK_PERIOD_NS  8
`define SEE_PROG_TIME_NS   5000000
`define SEE_PROG_CYCLES    (`SEE_PROG_TIME_NS / `SEE_CLK_PERIOD_NS)
`define SEE_PROG_CNT_W     20
`define SEE_SYNC_W         7
`define SEE_SYNC_IDLE      7'h30

`endif

/* File: pkg/see_pkg.sv */
// Types shared by the two-wire serial EEPROM slave.
package see_pkg;
    `include "see_defines.svh"

    // Transfer phases, Gray coded along the usual write path.
    typedef enum logic [2:0] {
        SEE_ST_IDLE    = 3'h0,
        SEE_ST_DEVADDR = 3'h1,
        SEE_ST_LOC_HI  = 3'h3,
        SEE_ST_LOC_LO  = 3'h2,
        SEE_ST_WDATA   = 3'h6,
        SEE_ST_RDATA   = 3'h7,
        SEE_ST_IGNORE  = 3'h5
    } see_state_t;

    // One received data byte together with the location it is bound for.
    typedef struct packed {
        logic [`SEE_LOC_W-1:0]  loc;
        logic [`SEE_BYTE_W-1:0] data;
    } see_wr_t;
endpackage

/* File: rtl/see_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
module see_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = store[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: bench/see_top_assertions.sv */
// Port-level assertions for the two-wire serial EEPROM slave.
module see_top_assertions #(
    parameter int PROG_CYCLES = 625000
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic power_good,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic select_pin_0,
    input wire logic select_pin_1,
    input wire logic select_pin_2,
    input wire logic write_protect,
    input wire logic standby,
    input wire logic prog_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [31:0] busy_cnt;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= prog_active ? busy_cnt + 32'h1 : 32'h0;
        end
    end
    property p_open_drain;
        !sda_oe_n |-> !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    property p_pg_quiet;
        !power_good [*5] |-> sda_oe_n && !prog_active;
    endproperty
    a_pg_quiet: assert property (p_pg_quiet) else $error("activity without power");
    property p_pg_standby;
        !power_good [*5] |-> standby;
    endproperty
    a_pg_standby: assert property (p_pg_standby) else $error("no standby at power loss");
    property p_excl;
        prog_active [*2] |-> !standby;
    endproperty
    a_excl: assert property (p_excl) else $error("standby while programming");
    property p_busy_silent;
        prog_active |-> sda_oe_n;
    endproperty
    a_busy_silent: assert property (p_busy_silent) else $error("bus answer while busy");
    property p_prog_len;
        prog_active |-> busy_cnt <= PROG_CYCLES + 8;
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("programming too long");
    property p_stop_idle;
        scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] (standby || prog_active);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("no standby after stop");
    property p_edge_low;
        disable iff (!rstn || !power_good) $changed(sda_oe_n) |-> !scl_in;
    endproperty
    a_edge_low: assert property (p_edge_low) else $error("data changed with clock high");
endmodule

bind see_top see_top_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_see_top_assertions (
    .clk_sys, .rstn, .power_good, .scl_in, .sda_in, .sda_out, .sda_oe_n, .select_pin_0,
    .select_pin_1, .select_pin_2, .write_protect, .standby, .prog_active);

/* File: bench/see_bus_master.sv */
// Behavioural two-wire bus master that makes the clock and pulls the data line.
module see_bus_master (
    input  wire logic clk_sys,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic step(input logic s, input logic p);
        repeat (8) @(posedge clk_sys);
        scl <= s;
        sda_pull <= p;
    endtask
    // The clock is lowered first so the data line is released while it is low; pulling it with the clock high makes the start.
    task automatic start();
        step(1'b0, sda_pull);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, sda_pull);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic bit_io(input logic d, output logic got);
        step(1'b0, sda_pull);
        step(1'b0, !d);
        step(1'b1, !d);
        repeat (7) @(posedge clk_sys);
        got = sda_wire;
    endtask
    // Sends a byte MSB first, or reads one when d is all ones, then the ninth clock.
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] got,
                        output logic nine_seen);
        logic b;
        got = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            got = {got[6:0], b};
        end
        bit_io(nine, nine_seen);
    endtask
endmodule

/* File: bench/test_serial_eeprom_2wire_slave.sv */
// Self-checking testbench for the two-wire serial EEPROM slave.
module test_serial_eeprom_2wire_slave;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 2000;
    logic       clk_sys = 1'b0;
    logic       rstn = 1'b0;
    logic       power_good = 1'b0;
    logic [2:0] sel = 3'h0;
    logic       write_protect = 1'b0;
    logic       sda_out, sda_oe_n, standby, prog_active, scl, sda_pull, sda_wire, a;
    logic [7:0] g;
    int         err_count = 0;
    int         num_checks = 0;
    int         cycles = 0;
    always #4 clk_sys = ~clk_sys;
    assign sda_wire = (!sda_oe_n ? sda_out : 1'b1) & !sda_pull;
    see_top #(.PROG_CYCLES(PROG)) i_see_top (.clk_sys, .rstn, .power_good, .scl_in(scl),
        .sda_in(sda_wire), .sda_out, .sda_oe_n, .select_pin_0(sel[0]), .select_pin_1(sel[1]),
        .select_pin_2(sel[2]), .write_protect, .standby, .prog_active);
    see_bus_master i_see_bus_master (.clk_sys, .sda_wire, .scl, .sda_pull);
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 100000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic [7:0] d, input logic ack);
        i_see_bus_master.xfer(d, 1'b1, g, a);
        chk("ack", {7'h0, a}, {7'h0, !ack});
    endtask
    task automatic open(input logic [13:0] loc);
        i_see_bus_master.start();
        wb({4'ha, sel, 1'b0}, 1'b1);
        wb({2'h0, loc[13:8]}, 1'b1);
        wb(loc[7:0], 1'b1);
    endtask
    task automatic wr(input logic [13:0] loc, input logic [7:0] d[$]);
        int n;
        open(loc);
        foreach (d[i]) wb(d[i], 1'b1);
        i_see_bus_master.stop();
        repeat (6) @(posedge clk_sys);
        chk("busy", {7'h0, prog_active}, 8'h01);
        i_see_bus_master.start();
        wb({4'ha, sel, 1'b0}, 1'b0);
        i_see_bus_master.stop();
        for (n = 0; n < PROG + 100 && prog_active !== 1'b0; n++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        chk("busy", {7'h0, prog_active}, 8'h00);
        chk("standby", {7'h0, standby}, 8'h01);
    endtask
    task automatic rd(input logic [13:0] loc, input logic [7:0] e[$]);
        open(loc);
        i_see_bus_master.start();
        wb({4'ha, sel, 1'b1}, 1'b1);
        foreach (e[i]) begin
            i_see_bus_master.xfer(8'hff, i == e.size() - 1, g, a);
            chk("data", g, e[i]);
        end
        i_see_bus_master.stop();
    endtask
    task automatic t_pg_low();
        i_see_bus_master.start();
        wb(8'ha0, 1'b0);
        i_see_bus_master.stop();
        chk("busy", {7'h0, prog_active}, 8'h00);
        @(posedge clk_sys);
        power_good <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("standby", {7'h0, standby}, 8'h01);
    endtask
    task automatic t_ids();
        for (int s = 0; s < 8; s++) begin
            @(posedge clk_sys);
            sel <= s[2:0];
            i_see_bus_master.start();
            wb({4'ha, s[2:0], 1'b0}, 1'b1);
            i_see_bus_master.start();
            wb({4'ha, s[2:0] ^ 3'h5, 1'b0}, 1'b0);
            i_see_bus_master.stop();
        end
        @(posedge clk_sys);
        sel <= 3'h0;
    endtask
    task automatic t_pages();
        wr(14'h0123, '{8'h5a});
        wr(14'h0120, '{8'h11, 8'h22});
        rd(14'h0120, '{8'h11, 8'h22});
        rd(14'h0123, '{8'h5a});
        wr(14'h3fc1, '{8'h77});
        wr(14'h3ffe, '{8'ha1, 8'ha2, 8'ha3});
        rd(14'h3ffe, '{8'ha1, 8'ha2});
        rd(14'h3fc0, '{8'ha3, 8'h77});
    endtask
    task automatic t_protect();
        @(posedge clk_sys);
        write_protect <= 1'b1;
        open(14'h0123);
        wb(8'ha5, 1'b0);
        i_see_bus_master.stop();
        repeat (4) @(posedge clk_sys);
        chk("busy", {7'h0, prog_active}, 8'h00);
        rd(14'h0123, '{8'h5a});
        write_protect <= 1'b0;
    endtask
    task automatic t_pg_drop();
        @(posedge clk_sys);
        power_good <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("standby", {7'h0, standby}, 8'h01);
        i_see_bus_master.start();
        wb(8'ha0, 1'b0);
        i_see_bus_master.stop();
        power_good <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        t_pg_low();
        t_ids();
        t_pages();
        t_protect();
        t_pg_drop();
        give_verdict();
    end
endmodule
